// [hdl/simon_top.sv]
// Summary of operation
// - Hold chip reset while supply stays below low-voltage threshold.
// - Rising threshold higher than falling threshold, giving hysteresis.
// - Option selects low, medium or high low-voltage threshold.
// - Drive external reset pin low during low-voltage reset.
// - Option enables or disables the low-voltage detector.
// - Bit 5 reads early-warning comparator live; 1 means below.
// - Early warning inactive while low-voltage detector disabled.
// - Early-warning threshold follows selected low-voltage setting.
// - With bit 6 set, each warning flag change requests interrupt.
// - No interrupt for rising crossing inside the reset delay.
// - Enable before slow rising crossing gives two interrupts.
// - Enable after rising crossing gives exactly one interrupt.
// - Pending interrupt clears when CPU enters service routine.
// - Interrupt reaches CPU only if enabled and CPU mask cleared.
// - Wait has no effect; interrupt wakes Wait but not Halt.
// - Control/status register frozen during Halt, except reset events still update bits 4 and 0.
// - Bit 4 set on low-voltage reset, cleared by writing zero.
// - Bit 0 set on watchdog reset; cleared by zero write or LV reset.
// - Pin and watchdog resets leave low-voltage flag unchanged.
// - Reset delay lasts 256 or 4096 cycles by option.
//
// Top of the supply integrity monitor. Assumes comparators, option bits
// and reset sources arrive asynchronously, and that the CPU core supplies
// its mask, low-power state and service-entry strobe on hclk.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module simon_top
   import simon_pkg::*;
#(
   parameter int DELAY_LONG = SIMON_DELAY_LONG
)
(
   // AHB-Lite clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Analog comparators and options (asynchronous)
   input  wire simon_cmp_s  cmp,
   input  wire simon_opt_s  opt,
   // Reset sources (asynchronous, active low)
   input  wire logic        ext_reset_n,
   input  wire logic        watchdog_reset_n,
   // External reset pin, open drain
   input  wire logic        reset_pin_in,
   output logic             reset_pin_out,
   output logic             reset_pin_oe,
   // CPU side
   input  wire logic        cpu_irq_masked,
   input  wire logic        cpu_irq_ack,
   input  wire logic        cpu_in_wait,
   input  wire logic        cpu_in_halt,
   output logic             cpu_reset_n,
   output logic             warn_irq,
   output logic             warn_wakeup
);
   localparam int SYNC_W = $bits(simon_cmp_s) + $bits(simon_opt_s) + 3;
   localparam logic [SIMON_DLY_W-1:0] DLY_SHORT_END =
      SIMON_DLY_W'(SIMON_DELAY_SHORT - 1);
   localparam logic [SIMON_DLY_W-1:0] DLY_LONG_END =
      SIMON_DLY_W'(DELAY_LONG - 1);

   simon_cmp_s        cmp_s;
   simon_opt_s        opt_s;
   logic              ext_rst_s;
   logic              wdg_rst_s;
   logic              pin_s;

   simon_sync #(.WIDTH(SYNC_W)) u_sync
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({cmp, opt, ext_reset_n, watchdog_reset_n, reset_pin_in}),
      .q       ({cmp_s, opt_s, ext_rst_s, wdg_rst_s, pin_s})
   );

   // Threshold selection and hysteresis.
   logic [1:0] thr_idx;
   logic       lv_rise_below;
   logic       lv_fall_below;
   logic       warn_rise_below;
   logic       warn_fall_below;
   logic       lv_below_r;
   logic       lv_below_nxt;
   logic       warn_raw_r;
   logic       warn_raw_nxt;

   assign thr_idx = (opt_s.lv_threshold == SIMON_THR_HIGH) ? SIMON_THR_HIGH :
                    (opt_s.lv_threshold == SIMON_THR_MED)  ? SIMON_THR_MED :
                    SIMON_THR_LOW;
   assign lv_rise_below   = cmp_s.lv_below_rise[thr_idx];
   assign lv_fall_below   = cmp_s.lv_below_fall[thr_idx];
   assign warn_rise_below = cmp_s.warn_below_rise[thr_idx];
   assign warn_fall_below = cmp_s.warn_below_fall[thr_idx];

   assign lv_below_nxt = lv_below_r ? lv_rise_below : lv_fall_below;
   assign warn_raw_nxt = warn_raw_r ? warn_rise_below : warn_fall_below;

   logic lv_active;
   assign lv_active = opt_s.lv_enable & lv_below_r;

   // Reset sequencer.
   simon_state_e           state_r;
   simon_state_e           state_nxt;
   logic [SIMON_DLY_W-1:0] dly_r;
   logic [SIMON_DLY_W-1:0] dly_nxt;
   logic [SIMON_DLY_W-1:0] dly_end;
   logic                   any_src;
   logic                   in_delay;

   assign any_src  = lv_active | ~ext_rst_s | ~wdg_rst_s;
   assign dly_end  = opt_s.long_delay ? DLY_LONG_END : DLY_SHORT_END;
   assign in_delay = (state_r != SIMON_RUN);

   always_comb
   begin
      state_nxt = state_r;
      dly_nxt   = dly_r;
      case (state_r)
         SIMON_RUN:
         begin
            if (any_src)
            begin
               state_nxt = SIMON_LVRST;
            end
         end
         SIMON_LVRST:
         begin
            dly_nxt = '0;
            if (!any_src)
            begin
               state_nxt = SIMON_DELAY;
            end
         end
         SIMON_DELAY:
         begin
            dly_nxt = dly_r + SIMON_DLY_W'(1);
            if (any_src)
            begin
               state_nxt = SIMON_LVRST;
            end
            else if (dly_r >= dly_end)
            begin
               state_nxt = SIMON_RUN;
            end
         end
         default:
         begin
            state_nxt = SIMON_LVRST;
         end
      endcase
   end

   // Control/status register and interrupt state.
   logic       warn_ie_r;
   logic       lv_flag_r;
   logic       wdg_flag_r;
   logic       warn_flag_r;
   logic       warn_prev_r;
   logic       pend_r;
   logic       warn_live;
   logic       warn_ie_nxt;
   logic       lv_flag_nxt;
   logic       wdg_flag_nxt;
   logic       warn_flag_nxt;
   logic       pend_nxt;
   logic       freeze;
   logic       csr_wr;
   logic [7:0] wbyte;
   logic       warn_toggle;
   logic       ie_rise;
   logic       lv_event;
   logic       wdg_event;
   logic       in_delay_r;

   assign warn_live = opt_s.lv_enable & warn_raw_r;
   assign freeze    = cpu_in_halt;

   // AHB-Lite address phase capture.
   logic       ap_valid;
   logic       dp_wr_r;
   logic [7:0] dp_addr_r;

   assign ap_valid = hsel & hready & (htrans == SIMON_HTRANS_NONSEQ);
   assign csr_wr   = dp_wr_r & (dp_addr_r == SIMON_CTRL_STATUS_ADDR);
   assign wbyte    = hwdata[7:0];

   assign warn_toggle = (warn_live != warn_prev_r);
   assign ie_rise     = csr_wr & wbyte[SIMON_WARN_IE_BIT] & ~warn_ie_r &
                        ~freeze;
   assign lv_event    = lv_active;
   assign wdg_event   = ~wdg_rst_s;

   assign warn_flag_nxt = freeze ? warn_flag_r : warn_live;
   assign warn_ie_nxt   = (csr_wr && !freeze) ? wbyte[SIMON_WARN_IE_BIT] :
                          warn_ie_r;

   // Set on LV reset; zero write clears
   assign lv_flag_nxt =
      lv_event ? 1'b1 :
      freeze ? lv_flag_r :
      (csr_wr && !wbyte[SIMON_LV_FLAG_BIT]) ? 1'b0 : lv_flag_r;

   // Set on watchdog; cleared by LV reset or zero write
   assign wdg_flag_nxt =
      lv_event ? 1'b0 :
      wdg_event ? 1'b1 :
      freeze ? wdg_flag_r :
      (csr_wr && !wbyte[SIMON_WDG_FLAG_BIT]) ? 1'b0 : wdg_flag_r;

   // Later crossings add the second only
   assign pend_nxt =
      (!in_delay_r && ((warn_toggle && warn_ie_r) || ie_rise)) ? 1'b1 :
      cpu_irq_ack ? 1'b0 :
      !warn_ie_nxt ? 1'b0 : pend_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_r <= SIMON_LVRST;
         dly_r   <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         dly_r   <= dly_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lv_below_r <= 1'b1;
         warn_raw_r <= 1'b1;
      end
      else
      begin
         lv_below_r <= lv_below_nxt;
         warn_raw_r <= warn_raw_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         warn_ie_r   <= SIMON_CSR_RESET[SIMON_WARN_IE_BIT];
         lv_flag_r   <= SIMON_CSR_RESET[SIMON_LV_FLAG_BIT];
         wdg_flag_r  <= SIMON_CSR_RESET[SIMON_WDG_FLAG_BIT];
         warn_flag_r <= SIMON_CSR_RESET[SIMON_WARN_FLAG_BIT];
         warn_prev_r <= SIMON_CSR_RESET[SIMON_WARN_FLAG_BIT];
         pend_r      <= 1'b0;
         in_delay_r  <= 1'b1;
      end
      else
      begin
         warn_ie_r   <= in_delay ? 1'b0 : warn_ie_nxt;
         lv_flag_r   <= lv_flag_nxt;
         wdg_flag_r  <= wdg_flag_nxt;
         warn_flag_r <= warn_flag_nxt;
         warn_prev_r <= warn_live;
         pend_r      <= in_delay ? 1'b0 : pend_nxt;
         in_delay_r  <= in_delay;
      end
   end

   // Bus slave: zero wait states, always OKAY.
   logic [7:0]  csr_view;
   logic [31:0] rd_mux;

   assign csr_view = {1'b0, warn_ie_r, warn_flag_r, lv_flag_r,
                      3'h0, wdg_flag_r};
   // Selected from the address phase so the word is in hrdata for the
   // whole data phase. A write in the data phase just before is not seen.
   assign rd_mux =
      (haddr == SIMON_CTRL_STATUS_ADDR) ? {24'h000000, csr_view} :
      (haddr == SIMON_OPTIONS_ADDR) ? {28'h0000000, opt_s} :
      (haddr == SIMON_PIN_STATUS_ADDR) ? {31'h00000000, pin_s} :
      32'h00000000;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr_r   <= 1'b0;
         dp_addr_r <= 8'h00;
      end
      else
      begin
         dp_wr_r   <= ap_valid & hwrite;
         dp_addr_r <= ap_valid ? haddr : dp_addr_r;
      end
   end

   // Outputs straight from flops.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata        <= 32'h00000000;
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         reset_pin_out <= 1'b0;
         reset_pin_oe  <= 1'b1;
         cpu_reset_n   <= 1'b0;
         warn_irq      <= 1'b0;
         warn_wakeup   <= 1'b0;
      end
      else
      begin
         hrdata        <= (ap_valid & ~hwrite) ? rd_mux : hrdata;
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         reset_pin_out <= 1'b0;
         reset_pin_oe  <= (state_nxt != SIMON_RUN);
         cpu_reset_n   <= (state_nxt == SIMON_RUN);
         warn_irq      <= pend_nxt & warn_ie_nxt & ~cpu_irq_masked &
                          (state_nxt == SIMON_RUN);
         warn_wakeup   <= pend_nxt & warn_ie_nxt & cpu_in_wait &
                          ~cpu_in_halt;
      end
   end

   // Transfer size is not decoded: every register is one whole word.
   logic unused_ok;
   assign unused_ok = &{hsize == SIMON_HSIZE_WORD, 1'b1};

endmodule : simon_top

// [hdl/simon_pkg.sv]
// Package for the supply integrity monitor: register map, field layout,
// option encodings and timing constants.
// Assumes a 32-bit AHB-Lite register bus clocked by hclk.
package simon_pkg;

   // Register map (byte addresses).
   localparam logic [7:0] SIMON_CTRL_STATUS_ADDR = 8'h00;
   localparam logic [7:0] SIMON_OPTIONS_ADDR     = 8'h04;
   localparam logic [7:0] SIMON_PIN_STATUS_ADDR  = 8'h08;

   // Field positions of the control/status register.
   localparam int SIMON_WDG_FLAG_BIT   = 0;
   localparam int SIMON_LV_FLAG_BIT    = 4;
   localparam int SIMON_WARN_FLAG_BIT  = 5;
   localparam int SIMON_WARN_IE_BIT    = 6;
   localparam logic [7:0] SIMON_CSR_RESET = 8'h00;

   // Low-voltage threshold selection codes.
   localparam logic [1:0] SIMON_THR_LOW  = 2'h0;
   localparam logic [1:0] SIMON_THR_MED  = 2'h1;
   localparam logic [1:0] SIMON_THR_HIGH = 2'h2;

   // Reset delay lengths in CPU cycles.
   localparam int SIMON_DELAY_SHORT = 256;
   localparam int SIMON_DELAY_LONG  = 4096;
   localparam int SIMON_DLY_W       = 13;

   // AHB-Lite encodings.
   localparam logic [1:0] SIMON_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] SIMON_HSIZE_WORD    = 3'h2;

   // Nonvolatile option settings.
   typedef struct packed {
      logic       lv_enable;
      logic [1:0] lv_threshold;
      logic       long_delay;
   } simon_opt_s;

   // Analog comparator outputs, one set per threshold setting.
   typedef struct packed {
      logic [2:0] lv_below_rise;
      logic [2:0] lv_below_fall;
      logic [2:0] warn_below_rise;
      logic [2:0] warn_below_fall;
   } simon_cmp_s;

   typedef enum logic [2:0] {
      SIMON_RUN   = 3'b001,
      SIMON_LVRST = 3'b010,
      SIMON_DELAY = 3'b100
   } simon_state_e;

endpackage : simon_pkg

// [hdl/simon_sync.sv]
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes its inputs come from analog comparators or pins.
`timescale 1ns/10ps
module simon_sync
   import simon_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : simon_sync

// [dv/simon_top_chk.sv]
// Checker for the supply monitor: reset hold, pin and interrupt timing.
// Assumes it is bound into simon_top and sees only its ports.
`timescale 1ns/10ps
module simon_top_chk
   import simon_pkg::*;
#(
   parameter int DELAY_LONG = SIMON_DELAY_LONG
)
(
   // Clock and reset
   input wire logic       hclk,
   input wire logic       hresetn,
   // Supply and options
   input wire simon_cmp_s cmp,
   input wire simon_opt_s opt,
   // Reset outputs
   input wire logic       cpu_reset_n,
   input wire logic       reset_pin_out,
   input wire logic       reset_pin_oe,
   // CPU side
   input wire logic       cpu_irq_masked,
   input wire logic       cpu_irq_ack,
   input wire logic       cpu_in_wait,
   input wire logic       cpu_in_halt,
   input wire logic       warn_irq,
   input wire logic       warn_wakeup
);
   logic [12:0] low_cnt;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Saturates so a long hold cannot wrap and look short.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         low_cnt <= 13'h0;
      else if (cpu_reset_n)
         low_cnt <= 13'h0;
      else if (low_cnt != 13'h1fff)
         low_cnt <= low_cnt + 13'h1;
   end

   sequence lv_low_s;
      opt.lv_enable && cmp.lv_below_fall[opt.lv_threshold];
   endsequence
   sequence entry_s;
      cpu_irq_ack ##1 !cpu_irq_ack;
   endsequence

   a_lv_hold:
      assert property (lv_low_s [*6] |-> !cpu_reset_n)
      else $error("core not held");
   a_pin_low:
      assert property (!cpu_reset_n |-> reset_pin_oe && !reset_pin_out)
      else $error("pin not pulled low");
   a_delay_len:
      assert property ($rose(cpu_reset_n) |->
         low_cnt >= (opt.long_delay ? DELAY_LONG : SIMON_DELAY_SHORT))
      else $error("delay too short");
   a_quiet_reset:
      assert property (!cpu_reset_n |-> !warn_irq)
      else $error("irq in reset");
   a_mask_blocks:
      assert property (cpu_irq_masked [*2] |-> !warn_irq)
      else $error("irq while masked");
   a_entry_clears:
      assert property (entry_s |-> ##[0:1] !warn_irq)
      else $error("irq not cleared");
   a_wait_wake:
      assert property (warn_irq && cpu_in_wait |-> ##[0:2] warn_wakeup)
      else $error("no wake");
   a_halt_nowake:
      assert property (cpu_in_halt [*2] |-> !warn_wakeup)
      else $error("woke in halt");
endmodule : simon_top_chk

bind simon_top simon_top_chk #(.DELAY_LONG(DELAY_LONG)) u_simon_top_chk (
   .hclk, .hresetn, .cmp, .opt, .cpu_reset_n, .reset_pin_out,
   .reset_pin_oe, .cpu_irq_masked, .cpu_irq_ack, .cpu_in_wait,
   .cpu_in_halt, .warn_irq, .warn_wakeup
);

// [dv/simon_cpu_model.sv]
// Interrupt entry model of the CPU facing the supply monitor.
// Assumes warn_irq is a level request that drops after entry.
`timescale 1ns/10ps
module simon_cpu_model
#(
   parameter int SLOW = 0
)
(
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Interrupt handshake
   input  wire logic warn_irq,
   input  wire logic cpu_irq_masked,
   output logic      cpu_irq_ack,
   output int        services
);
   int wait_r;

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         cpu_irq_ack <= 1'b0;
         wait_r      <= 0;
         services    <= 0;
      end
      else if (cpu_irq_ack || !warn_irq || cpu_irq_masked)
      begin
         cpu_irq_ack <= 1'b0;
         wait_r      <= 0;
      end
      else if (wait_r > SLOW)
      begin
         cpu_irq_ack <= 1'b1;
         services    <= services + 1;
      end
      else
         wait_r <= wait_r + 1;
endmodule : simon_cpu_model

// [dv/tb_simon_top.sv]
// Bench for the supply monitor: bus tasks, supply and reset stimulus.
// Assumes a zero-wait bus slave and a short long-delay parameter.
`timescale 1ns/10ps
module tb_simon_top
   import simon_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata;
   logic        ext_reset_n, watchdog_reset_n, reset_pin_out, reset_pin_oe;
   logic        cpu_irq_masked, cpu_irq_ack, cpu_in_wait, cpu_in_halt;
   logic        cpu_reset_n, warn_irq, warn_wakeup;
   simon_cmp_s  cmp;
   simon_opt_s  opt;
   int          services, err_total, check_count;
   // The pin has a pull-up, so it reads high unless driven.
   wire         pin_lvl = reset_pin_oe ? reset_pin_out : 1'b1;

   simon_top #(.DELAY_LONG(64)) u_simon_top (.hclk, .hresetn, .hsel,
      .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .cmp, .opt, .ext_reset_n,
      .watchdog_reset_n, .reset_pin_in(pin_lvl), .reset_pin_out,
      .reset_pin_oe, .cpu_irq_masked, .cpu_irq_ack, .cpu_in_wait,
      .cpu_in_halt, .cpu_reset_n, .warn_irq, .warn_wakeup);
   simon_cpu_model #(.SLOW(2)) u_simon_cpu_model (.hclk, .hresetn,
      .warn_irq, .cpu_irq_masked, .cpu_irq_ack, .services);

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic conclude();
      if (err_total == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wait_sig(logic sel, logic lvl);
      int n;
      n = 0;
      while ((sel ? cpu_reset_n : hreadyout) !== lvl && n < 5000)
      begin
         @(posedge hclk);
         n++;
      end
      if (n >= 5000)
      begin
         err_total++;
         conclude();
      end
   endtask : wait_sig

   task automatic bus(logic w, logic [7:0] a, logic [7:0] d,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= SIMON_HTRANS_NONSEQ;
      hwrite <= w;
      hsize  <= SIMON_HSIZE_WORD;
      @(posedge hclk);
      wait_sig(1'b0, 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      wait_sig(1'b0, 1'b1);
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : bus

   task automatic wr(logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, SIMON_CTRL_STATUS_ADDR, d, q);
   endtask : wr

   task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m);
      logic [31:0] q;
      bus(1'b0, a, 8'h0, q);
      chk("csr", {24'h0, e & m}, q & {24'hffffff, m});
   endtask : rd

   task automatic warn(logic [2:0] v);
      cmp.warn_below_rise <= v;
      cmp.warn_below_fall <= v;
      repeat (30) @(posedge hclk);
   endtask : warn

   task automatic src(int k);
      if (k == 0)
      begin
         cmp.lv_below_rise <= 3'h2;
         cmp.lv_below_fall <= 3'h2;
         repeat (20) @(posedge hclk);
         chk("held", 0, cpu_reset_n);
         chk("pin_oe", 1, reset_pin_oe);
         cmp.lv_below_rise <= 3'h0;
         cmp.lv_below_fall <= 3'h0;
      end
      else if (k == 1)
         watchdog_reset_n <= 1'b0;
      else
         ext_reset_n <= 1'b0;
      repeat (4) @(posedge hclk);
      watchdog_reset_n <= 1'b1;
      ext_reset_n      <= 1'b1;
      wait_sig(1'b1, 1'b1);
   endtask : src

   initial
   begin
      {hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
      cmp = '0;
      opt = '{1'b1, SIMON_THR_MED, 1'b1};
      {ext_reset_n, watchdog_reset_n} = 2'h3;
      {cpu_irq_masked, cpu_in_wait, cpu_in_halt} = 3'h0;
      err_total = 0;
      check_count = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      wait_sig(1'b1, 1'b1);
      chk("pin_oe", 0, reset_pin_oe);
      rd(8'hfc, 8'h0, 8'hff);
      wr(8'h40);
      warn(3'h0);
      chk("irq", 1, services);
      warn(3'h2);
      chk("irq", 2, services);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h60, 8'hff);
      cpu_irq_masked <= 1'b1;
      warn(3'h0);
      chk("irq", 2, services);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h40, 8'hff);
      cpu_irq_masked <= 1'b0;
      cpu_in_wait    <= 1'b1;
      warn(3'h0);
      chk("irq", 3, services);
      warn(3'h2);
      chk("irq", 4, services);
      cpu_in_wait <= 1'b0;
      cpu_in_halt <= 1'b1;
      wr(8'h00);
      cpu_in_halt <= 1'b0;
      rd(SIMON_CTRL_STATUS_ADDR, 8'h60, 8'hff);
      wr(8'h00);
      wr(8'h40);
      warn(3'h2);
      chk("irq", 5, services);
      warn(3'h0);
      chk("irq", 6, services);
      cmp.lv_below_rise <= 3'h5;
      cmp.lv_below_fall <= 3'h5;
      repeat (20) @(posedge hclk);
      chk("run", 1, cpu_reset_n);
      src(0);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h10, 8'h11);
      opt.long_delay <= 1'b0;
      src(1);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h11, 8'h11);
      wr(8'h11);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h11, 8'h11);
      src(0);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h10, 8'h11);
      wr(8'h00);
      src(2);
      rd(SIMON_CTRL_STATUS_ADDR, 8'h00, 8'h11);
      opt.lv_enable     <= 1'b0; // flags not read from here on
      cmp.lv_below_rise <= 3'h7;
      cmp.lv_below_fall <= 3'h7;
      repeat (20) @(posedge hclk);
      chk("run", 1, cpu_reset_n);
      conclude();
   end
endmodule : tb_simon_top
